/* File: src/spi_cfg_pkg.sv */
/*
 * Shared constants and types for the serial configuration register bank:
 * register offsets, field positions, reset values, reset-pulse timing and
 * the carrier structs. Assumes a 10 MHz system clock.
 */
package spi_cfg_pkg;

   // clock and soft-reset pulse timing
   localparam int SYS_CLK_NS        = 100;
   localparam int SOFT_RESET_NS     = 1000;
   localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int PULSE_CNT_W       = 16;

   // serial frame layout
   localparam int ADDR_W     = 15;
   localparam int INSTR_BITS = 16;
   localparam int BYTE_BITS  = 8;

   // register offsets
   localparam logic [14:0] ADDR_CFG_A      = 15'h0000;
   localparam logic [14:0] ADDR_CFG_B      = 15'h0001;
   localparam logic [14:0] ADDR_CLASS_CODE = 15'h0003;
   localparam logic [14:0] ADDR_PART_LOW   = 15'h0004;
   localparam logic [14:0] ADDR_PART_HIGH  = 15'h0005;
   localparam logic [14:0] ADDR_GRADE_REV  = 15'h0006;

   // interface_config_a fields
   localparam int CFGA_CORE_RESET = 0;
   localparam int CFGA_BIT_ORDER  = 1;
   localparam int CFGA_ADDR_DIR   = 2;
   localparam int CFGA_FOUR_WIRE  = 3;
   localparam logic [3:0] CFG_A_RESET = 4'h0;

   // interface_config_b fields
   localparam int CFGB_SINGLE_INS = 7;
   localparam int CFGB_STALL      = 6;
   localparam int CFGB_AUX_ONE    = 2;
   localparam int CFGB_AUX_ZERO   = 1;
   localparam logic [7:0] CFG_B_RESET = 8'h00;

   // soft reset lines: index into the pulser vector
   localparam int RST_CORE = 0;
   localparam int RST_AUX0 = 1;
   localparam int RST_AUX1 = 2;
   localparam int RST_LINES = 3;

   typedef enum logic [1:0] {PH_IDLE, PH_INSTR, PH_DATA, PH_HOLD} phase_e;

   // synchronised serial pins
   typedef struct packed {
      logic sclk;
      logic csN;
      logic sdi;
   } pins_s;

   // read-data pin drive
   typedef struct packed {
      logic sdioOut;
      logic sdioOe;
      logic sdoOut;
      logic sdoOe;
   } drive_s;

   // reset pulser state
   typedef struct packed {
      logic [PULSE_CNT_W-1:0] cnt;
      logic                   pulse;
      logic                   done;
   } pulser_s;

   // main register bank and serial engine state
   typedef struct packed {
      phase_e            phase;
      logic              prevSclk;
      logic [4:0]        bitCnt;
      logic [15:0]       shiftIn;
      logic [ADDR_W-1:0] addr;
      logic              isRead;
      logic [7:0]        outByte;
      drive_s            drive;
      logic [3:0]        cfgA;
      logic              single_instruction_mode;
      logic              stallEn;
      logic              aux1Req;
      logic              aux0Req;
      logic [2:0]        resetStart;
   } bank_s;

endpackage

/* File: src/sync_stage.sv */
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; no bit-to-bit coherency is given.
 */
module sync_stage
   import spi_cfg_pkg::*;
#(
   parameter int WIDTH = 3
)(
   input  wire logic             sysClk,  // system clock
   input  wire logic             rstn,    // async reset, active low
   input  wire logic [WIDTH-1:0] async,   // levels from outside the domain
   output logic      [WIDTH-1:0] synced   // levels safe to use
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s s;
   sync_s next_s;

   // first stage is read only by the second stage
   always_comb
   begin
      next_s.meta   = async;
      next_s.stable = s.meta;
   end

   always_ff @(posedge sysClk or negedge rstn)
   begin
      if (!rstn)
         s <= '0;
      else
         s <= next_s;
   end

   assign synced = s.stable;

endmodule

/* File: src/reset_pulser.sv */
/*
 * Self-timed soft reset pulse: a start strobe gives a pulse of CYCLES
 * clocks and then a one-cycle done strobe. Assumes start is synchronous.
 */
module reset_pulser
   import spi_cfg_pkg::*;
#(
   parameter int CYCLES = SOFT_RESET_CYCLES
)(
   input  wire logic sysClk,  // system clock
   input  wire logic rstn,    // async reset, active low
   input  wire logic start,   // one-cycle request
   output logic      pulse,   // reset line, high while active
   output logic      done     // one-cycle end of pulse
);

   pulser_s s;
   pulser_s next_s;

   // count down while the pulse stands; a restart extends it
   always_comb
   begin
      next_s      = s;
      next_s.done = 1'b0;
      if (start)
      begin
         next_s.pulse = 1'b1;
         next_s.cnt   = PULSE_CNT_W'(CYCLES - 1);
      end
      else if (s.pulse)
      begin
         if (s.cnt == '0)
         begin
            next_s.pulse = 1'b0;
            next_s.done  = 1'b1;
         end
         else
            next_s.cnt = s.cnt - 1'b1;
      end
   end

   always_ff @(posedge sysClk or negedge rstn)
   begin
      if (!rstn)
         s <= '0;
      else
         s <= next_s;
   end

   assign pulse = s.pulse;
   assign done  = s.done;

endmodule

/* File: src/spi_config_regs.sv */
/*
 * Serial configuration and identification register bank with its serial
 * port engine. The host drives sclk, csN and sdio; sclk is sampled by
 * sysClk, so sclk must be well below a quarter of the system clock rate.
 */
// Summary of operation
// - Upper nibble of config A reads as mirror of bits 0 to 3.
// - Four-wire bit set: read data leave on sdo instead of sdio.
// - Streaming address rises when direction bit is 1, falls when 0.
// - Bit order bit set: data shift in and out LSB first, else MSB.
// - Writing core reset bit pulses device reset; bit clears when done.
// - Config B bit 2 pulses auxiliary reset one, then clears itself.
// - Config B bit 1 pulses auxiliary reset zero, then clears itself.
module spi_config_regs
   import spi_cfg_pkg::*;
#(
   parameter logic [7:0]  CLASS_CODE  = 8'h5A,     // arbitrary value
   parameter logic [15:0] PART_CODE   = 16'hA5_C3, // arbitrary value
   parameter logic [3:0]  PART_GRADE  = 4'h1,      // arbitrary value
   parameter logic [3:0]  SILICON_REV = 4'h2,      // arbitrary value
   parameter int          RESET_LEN   = SOFT_RESET_CYCLES
)(
   input  wire logic sysClk,     // system clock, 10 MHz
   input  wire logic rstn,       // async reset, active low
   input  wire logic sclk,       // serial clock pin
   input  wire logic csN,        // chip select pin, active low
   input  wire logic sdioIn,     // sdio pin level
   output logic      sdioOut,    // sdio drive value
   output logic      sdioOe,     // sdio drive enable
   output logic      sdoOut,     // sdo drive value
   output logic      sdoOe,      // sdo drive enable
   output logic      coreReset,  // device soft reset line
   output logic      auxReset0,  // auxiliary soft reset zero
   output logic      auxReset1   // auxiliary soft reset one
);

   bank_s               s;
   bank_s               next_s;
   pins_s               pinsRaw;
   pins_s               pins;
   logic                rise;
   logic                fall;
   logic                bit_order_select;
   logic [15:0]         word;
   logic [7:0]          byteIn;
   logic [ADDR_W-1:0]   nextAddr;
   logic                outBit;
   logic [RST_LINES-1:0] rstPulse;
   logic [RST_LINES-1:0] rstDone;

   // every pin is asynchronous to sysClk
   assign pinsRaw = '{sclk: sclk, csN: csN, sdi: sdioIn};

   sync_stage #(
      .WIDTH ($bits(pins_s))
   ) pinSync (
      .sysClk (sysClk),
      .rstn   (rstn),
      .async  (pinsRaw),
      .synced (pins)
   );

   // one pulser per soft reset line
   genvar g;
   generate
      for (g = 0; g < RST_LINES; g++)
      begin : gPulse
         reset_pulser #(
            .CYCLES (RESET_LEN)
         ) pulser (
            .sysClk (sysClk),
            .rstn   (rstn),
            .start  (s.resetStart[g]),
            .pulse  (rstPulse[g]),
            .done   (rstDone[g])
         );
      end
   endgenerate

   // register read decode, used at instruction end and on each stream step
   function automatic logic [7:0] readReg(input logic [ADDR_W-1:0] a, input bank_s b);
      logic [7:0] d;
      d = 8'h00;
      unique case (a)
         ADDR_CFG_A:      d = {b.cfgA[0], b.cfgA[1], b.cfgA[2], b.cfgA[3], b.cfgA};
         ADDR_CFG_B:      d = {b.single_instruction_mode, b.stallEn, 3'b000, b.aux1Req, b.aux0Req, 1'b0};
         ADDR_CLASS_CODE: d = CLASS_CODE;
         ADDR_PART_LOW:   d = PART_CODE[7:0];
         ADDR_PART_HIGH:  d = PART_CODE[15:8];
         ADDR_GRADE_REV:  d = {PART_GRADE, SILICON_REV};
         default:         d = 8'h00;
      endcase
      return d;
   endfunction

   // edges of the sampled serial clock
   assign rise     = pins.sclk & ~s.prevSclk;
   assign fall     = ~pins.sclk & s.prevSclk;
   assign bit_order_select = s.cfgA[CFGA_BIT_ORDER];

   // serial engine and register bank
   always_comb
   begin
      next_s            = s;
      word              = '0;
      byteIn            = '0;
      nextAddr          = s.addr;
      outBit            = 1'b0;
      next_s.prevSclk   = pins.sclk;
      next_s.resetStart = '0;

      // completions first, so a write in the same cycle wins
      if (rstDone[RST_CORE])
      begin
         next_s.cfgA      = CFG_A_RESET;
         next_s.single_instruction_mode = CFG_B_RESET[CFGB_SINGLE_INS];
         next_s.stallEn   = CFG_B_RESET[CFGB_STALL];
      end
      if (rstDone[RST_AUX0])
         next_s.aux0Req = 1'b0;
      if (rstDone[RST_AUX1])
         next_s.aux1Req = 1'b0;

      if (pins.csN)
      begin
         // deselected: abort any frame and release the pins
         next_s.phase        = PH_IDLE;
         next_s.bitCnt       = '0;
         next_s.drive.sdioOe = 1'b0;
         next_s.drive.sdoOe  = 1'b0;
      end
      else
      begin
         unique case (s.phase)
            PH_IDLE:
            begin
               next_s.phase  = PH_INSTR;
               next_s.bitCnt = '0;
            end
            PH_INSTR:
            begin
               if (rise)
               begin
                  // rw bit is the top of the instruction word in either order
                  if (bit_order_select)
                     word = {pins.sdi, s.shiftIn[15:1]};
                  else
                     word = {s.shiftIn[14:0], pins.sdi};
                  next_s.shiftIn = word;
                  next_s.bitCnt  = s.bitCnt + 1'b1;
                  if (s.bitCnt == 5'(INSTR_BITS - 1))
                  begin
                     next_s.addr    = word[ADDR_W-1:0];
                     next_s.isRead  = word[15];
                     next_s.outByte = readReg(word[ADDR_W-1:0], s);
                     next_s.bitCnt  = '0;
                     next_s.phase   = PH_DATA;
                  end
               end
            end
            PH_DATA:
            begin
               if (rise)
               begin
                  if (bit_order_select)
                     byteIn = {pins.sdi, s.shiftIn[7:1]};
                  else
                     byteIn = {s.shiftIn[6:0], pins.sdi};
                  next_s.shiftIn = {8'h00, byteIn};
                  next_s.bitCnt  = s.bitCnt + 1'b1;
                  if (s.bitCnt == 5'(BYTE_BITS - 1))
                  begin
                     if (!s.isRead)
                     begin
                        unique case (s.addr)
                           ADDR_CFG_A:
                           begin
                              // request bit holds until its pulse completes;
                              // a set in the completion cycle wins over the clear
                              next_s.cfgA = {byteIn[3:1],
                                 next_s.cfgA[CFGA_CORE_RESET] | byteIn[CFGA_CORE_RESET]};
                              next_s.resetStart[RST_CORE] = byteIn[CFGA_CORE_RESET];
                           end
                           ADDR_CFG_B:
                           begin
                              next_s.single_instruction_mode = byteIn[CFGB_SINGLE_INS];
                              next_s.stallEn   = byteIn[CFGB_STALL];
                              next_s.aux1Req   = next_s.aux1Req | byteIn[CFGB_AUX_ONE];
                              next_s.aux0Req   = next_s.aux0Req | byteIn[CFGB_AUX_ZERO];
                              next_s.resetStart[RST_AUX1] = byteIn[CFGB_AUX_ONE];
                              next_s.resetStart[RST_AUX0] = byteIn[CFGB_AUX_ZERO];
                           end
                           // identification and unmapped addresses: ignored
                           default: ;
                        endcase
                     end
                     if (s.cfgA[CFGA_ADDR_DIR])
                        nextAddr = s.addr + 1'b1;
                     else
                        nextAddr = s.addr - 1'b1;
                     next_s.addr    = nextAddr;
                     next_s.outByte = readReg(nextAddr, s);
                     next_s.bitCnt  = '0;
                     if (s.single_instruction_mode)
                        next_s.phase = PH_HOLD; // one byte per frame
                  end
               end
               // read data change on the falling edge, ahead of the host sample
               if (fall && s.isRead)
               begin
                  outBit = bit_order_select ? s.outByte[0] : s.outByte[7];
                  if (bit_order_select)
                     next_s.outByte = {1'b0, s.outByte[7:1]};
                  else
                     next_s.outByte = {s.outByte[6:0], 1'b0};
                  if (s.cfgA[CFGA_FOUR_WIRE])
                  begin
                     next_s.drive.sdoOut = outBit;
                     next_s.drive.sdoOe  = 1'b1;
                     next_s.drive.sdioOe = 1'b0;
                  end
                  else
                  begin
                     next_s.drive.sdioOut = outBit;
                     next_s.drive.sdioOe  = 1'b1;
                     next_s.drive.sdoOe   = 1'b0;
                  end
               end
            end
            PH_HOLD:
            begin
               // single instruction: wait out the frame, stop driving
               if (fall)
               begin
                  next_s.drive.sdioOe = 1'b0;
                  next_s.drive.sdoOe  = 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sysClk or negedge rstn)
   begin
      if (!rstn)
      begin
         s       <= '0;
         s.phase <= PH_IDLE;
      end
      else
         s <= next_s;
   end

   // pin drives are state bits; reset lines come from pulser flops
   assign sdioOut   = s.drive.sdioOut;
   assign sdioOe    = s.drive.sdioOe;
   assign sdoOut    = s.drive.sdoOut;
   assign sdoOe     = s.drive.sdoOe;
   assign coreReset = rstPulse[RST_CORE];
   assign auxReset0 = rstPulse[RST_AUX0];
   assign auxReset1 = rstPulse[RST_AUX1];

endmodule

/* File: tb/spi_config_regs_props.sv */
/* Port checker for the serial configuration register bank.
   Assumes a host with an 800 ns serial clock; bound by the statement below. */
module spi_config_regs_props #(
   parameter int RESET_LEN = 10
)(
   input wire logic sysClk,     // system clock
   input wire logic rstn,       // async reset, active low
   input wire logic sclk,       // serial clock pin
   input wire logic csN,        // chip select, active low
   input wire logic sdioIn,     // sdio pin level
   input wire logic sdioOut,    // sdio drive value
   input wire logic sdioOe,     // sdio drive enable
   input wire logic sdoOut,     // sdo drive value
   input wire logic sdoOe,      // sdo drive enable
   input wire logic coreReset,  // soft reset line
   input wire logic auxReset0,  // aux reset zero
   input wire logic auxReset1   // aux reset one
);
   logic [2:0][15:0] run;
   default clocking @(posedge sysClk); endclocking
   default disable iff (!rstn);
   // high-run length of each reset line, kept so the fall can be judged
   always_ff @(posedge sysClk or negedge rstn)
   begin
      if (!rstn)
      begin
         run <= '0;
      end
      else
      begin
         run[0] <= coreReset ? run[0] + 16'h0001 : 16'h0000;
         run[1] <= auxReset0 ? run[1] + 16'h0001 : 16'h0000;
         run[2] <= auxReset1 ? run[2] + 16'h0001 : 16'h0000;
      end
   end
   core_pulse_len_a: assert property ($fell(coreReset) |-> run[0] == RESET_LEN)
      else $error("core reset pulse length wrong");
   aux0_pulse_len_a: assert property ($fell(auxReset0) |-> run[1] == RESET_LEN)
      else $error("aux reset zero pulse length wrong");
   aux1_pulse_len_a: assert property ($fell(auxReset1) |-> run[2] == RESET_LEN)
      else $error("aux reset one pulse length wrong");
   single_drive_a: assert property (!(sdioOe && sdoOe))
      else $error("read data driven on both pins");
   drive_release_a: assert property ($rose(csN) |-> ##[1:4] !(sdioOe || sdoOe))
      else $error("read drive kept after deselect");
   drive_selected_a: assert property ($rose(sdioOe || sdoOe) |-> !csN)
      else $error("read drive started while deselected");
   data_after_fall_a: assert property (sdioOe && $past(sdioOe) && $changed(sdioOut)
      |-> !$past(sclk, 2))
      else $error("read bit changed away from a clock fall");
   core_start_a: assert property ($rose(coreReset) |-> !$past(csN, 3))
      else $error("core reset started without a serial write");
   cover property ($fell(coreReset));
   cover property ($rose(sdoOe));
   cover property ($rose(sdioOe));
endmodule

bind spi_config_regs spi_config_regs_props #(.RESET_LEN(RESET_LEN)) spi_config_regs_props_inst (
   .sysClk(sysClk), .rstn(rstn), .sclk(sclk), .csN(csN), .sdioIn(sdioIn),
   .sdioOut(sdioOut), .sdioOe(sdioOe), .sdoOut(sdoOut), .sdoOe(sdoOe),
   .coreReset(coreReset), .auxReset0(auxReset0), .auxReset1(auxReset1));

/* File: tb/spi_host_model.sv */
/* Behavioural host on the serial port: frames, bit order, read sampling.
   Assumes the bench resolves the sdio and sdo levels it is given. */
module spi_host_model (
   output logic      sclk,      // serial clock, idles low
   output logic      csN,       // chip select, active low
   output logic      hostSdi,   // host drive onto sdio
   input  wire logic sdioLine,  // resolved sdio level
   input  wire logic sdoLine    // resolved sdo level
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle pins from time zero
   initial
   begin
      sclk = 1'b0;
      csN = 1'b1;
      hostSdi = 1'b0;
   end
   // one frame; released sdio toggles so a stale level never reads as data
   task automatic xfer(input logic rd, input logic [14:0] addr, input logic [31:0] wd,
                       input int nb, input logic lsb, input logic four,
                       output logic [31:0] got);
      logic [15:0] ins;
      int j;
      ins = {rd, addr};
      got = '0;
      #37 csN = 1'b0;
      #400;
      for (int i = 0; i < 16 + 8 * nb; i++)
      begin
         j = (i < 16) ? (lsb ? i : 15 - i) : 8 * ((i - 16) / 8) + (lsb ? i % 8 : 7 - i % 8);
         sclk = 1'b0;
         hostSdi = (i < 16) ? ins[j] : (rd ? ~hostSdi : wd[j]);
         #400 sclk = 1'b1;
         #400;
         // sample just before the next fall, when the bit has surely settled
         if (rd && i >= 16)
         begin
            got[j] = four ? sdoLine : sdioLine;
         end
      end
      sclk = 1'b0;
      #400 csN = 1'b1;
      #800;
   endtask
endmodule

/* File: tb/spi_config_regs_bench.sv */
/* Self-checking bench: reference register model, pulse monitor, verdict.
   Assumes the host model and checker are compiled before it. */
module spi_config_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int          PULSE_LEN = 10;
   localparam logic [7:0]  CLASS = 8'h3c;    // arbitrary value
   localparam logic [15:0] PART  = 16'h9e61; // arbitrary value
   localparam logic [3:0]  GRADE = 4'h7;     // arbitrary value
   localparam logic [3:0]  REV   = 4'h4;     // arbitrary value
   logic       sysClk = 1'b0;
   logic       rstn = 1'b0;
   logic       sclk, csN, hostSdi, sdioOut, sdioOe, sdoOut, sdoOe;
   logic       coreReset, auxReset0, auxReset1;
   logic [7:0] seed = 8'h35;
   wire        sdioLine = sdioOe ? sdioOut : hostSdi;
   wire        sdoLine = sdoOe ? sdoOut : ~sdoOut;
   wire [2:0]  lines = {auxReset1, auxReset0, coreReset};
   int         err_total = 0, comparisons = 0, cycles = 0, cfgA = 0, cfgB = 0;
   int         runLen[3] = '{0, 0, 0}, pulses[3] = '{0, 0, 0}, wantPulses[3] = '{0, 0, 0};
   int         resetTab[$] = '{2, 4, 70};

   spi_host_model spi_host_model_inst (.sclk(sclk), .csN(csN), .hostSdi(hostSdi),
      .sdioLine(sdioLine), .sdoLine(sdoLine));
   spi_config_regs #(.CLASS_CODE(CLASS), .PART_CODE(PART), .PART_GRADE(GRADE),
      .SILICON_REV(REV), .RESET_LEN(PULSE_LEN)) spi_config_regs_inst (
      .sysClk(sysClk), .rstn(rstn), .sclk(sclk), .csN(csN), .sdioIn(sdioLine),
      .sdioOut(sdioOut), .sdioOe(sdioOe), .sdoOut(sdoOut), .sdoOe(sdoOe),
      .coreReset(coreReset), .auxReset0(auxReset0), .auxReset1(auxReset1));

   always #50 sysClk = ~sysClk;

   function automatic logic [7:0] nextRand(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // reference read value; upper nibble of config a mirrors bits 0 to 3
   function automatic int regAt(int a);
      case (a & 32'h0000_7fff)
         0: return (cfgA & 15) | (cfgA & 1) << 7 | (cfgA & 2) << 5 | (cfgA & 4) << 3 | (cfgA & 8) << 1;
         1: return cfgB;
         3: return CLASS;
         4: return PART[7:0];
         5: return PART[15:8];
         6: return {GRADE, REV};
         default: return 0;
      endcase
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input int addr, input int nb, input string what);
      logic [31:0] got;
      int step;
      step = (cfgA & 4) ? 1 : -1;
      spi_host_model_inst.xfer(1'b1, addr[14:0], 32'h0000_0000, nb, cfgA[1], cfgA[3], got);
      for (int k = 0; k < nb; k++)
      begin
         check(what, got[8 * k +: 8], 8'(regAt(addr + k * step)));
      end
   endtask
   // write frame, then let any reset pulse finish before the model clears bits
   task automatic wr(input int addr, input int data, input int nb);
      logic [31:0] unused;
      int a, b, core, n;
      core = 0;
      // single instruction: only the first byte of the frame is taken
      n = (cfgB & 8'h80) ? 1 : nb;
      spi_host_model_inst.xfer(1'b0, addr[14:0], data, nb, cfgA[1], cfgA[3], unused);
      for (int k = 0; k < n; k++)
      begin
         a = addr + k * ((cfgA & 4) ? 1 : -1);
         b = (data >> 8 * k) & 255;
         if (a == 0)
         begin
            cfgA = b & 15;
            core = b & 1;
         end
         if (a == 1)
         begin
            cfgB = b & 8'hc6;
            wantPulses[1] += (b >> 1) & 1;
            wantPulses[2] += (b >> 2) & 1;
         end
      end
      wantPulses[0] += core;
      repeat (2 * PULSE_LEN + 8) @(posedge sysClk);
      cfgA = core ? 0 : cfgA & 14;
      cfgB = core ? 0 : cfgB & 8'hc0;
   endtask
   task automatic give_verdict();
      if (err_total == 0 && comparisons > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // pulse lengths and counts, plus the hang limit
   always @(posedge sysClk)
   begin
      cycles++;
      foreach (runLen[i])
      begin
         if (lines[i])
         begin
            runLen[i]++;
         end
         else if (runLen[i] > 0)
         begin
            pulses[i]++;
            check("pulse length", 8'(runLen[i]), 8'(PULSE_LEN));
            runLen[i] = 0;
         end
      end
      // hang limit last, so nothing in this process follows the finish
      if (cycles == 40000)
      begin
         err_total++;
         give_verdict();
      end
   end

   // main sequence: reset values, streaming, read-only ids, modes, resets
   initial
   begin
      repeat (12) @(posedge sysClk);
      #37 rstn = 1'b1;
      repeat (6) @(posedge sysClk);
      rd(0, 2, "reset values");
      rd(2, 1, "reserved");
      wr(0, 4, 1);
      rd(0, 1, "mirror");
      rd(3, 4, "ids upward");
      seed = nextRand(seed);
      wr(3, {4{seed}}, 4);
      rd(3, 4, "ids after write");
      wr(0, 0, 1);
      rd(6, 4, "ids downward");
      // every mode combination; mirror bits written at random must not stick
      for (int m = 0; m < 8; m++)
      begin
         seed = nextRand(seed);
         wr(0, {seed[7:4], m[2:0], 1'b0}, 1);
         wr(1, seed & 8'h79, 1);
         rd(0, 2, "mode walk");
      end
      foreach (resetTab[i])
      begin
         wr(1, resetTab[i], 1);
         rd(1, 1, "aux self clear");
      end
      // single instruction: the second byte of a frame must be dropped
      wr(1, 8'h80, 1);
      wr(0, cfgA & 14, 2);
      rd(1, 1, "single instruction");
      wr(0, 8'h0f, 1);
      rd(0, 2, "core self clear");
      foreach (pulses[i]) check("pulse count", 8'(pulses[i]), 8'(wantPulses[i]));
      give_verdict();
   end
endmodule
